// file: dv/ebdws_decode_bench.sv
/* Self-checking bench: access table, pin function, clock enables, reset.
   Assumes the partner model and the bound checker. */
`timescale 1ns/1ps
module ebdws_decode_bench;
   typedef struct packed {
      logic [15:0] a; logic w; logic [1:0] m; logic lo, hi, b16, ie;
      logic [2:0] rg; logic ex, er, sl, sg;
   } ebdws_row_t;
   logic clk = 1'b0, rstn = 1'b0, accValid = 1'b0, accWrite = 1'b0, accLowByte = 1'b0;
   logic accHighByte = 1'b0, busWidth16 = 1'b1, internalMemEnable = 1'b1, fetchNext = 1'b0;
   logic port5_pin_function_bit2 = 1'b1, write_strobe_select_bit = 1'b0, port5Bit2Data = 1'b0;
   logic [15:0] accAddr = 16'h0000;
   logic [1:0]  accMode = 2'h0;
   wire [15:0] fetchAddr_ff;
   wire [2:0]  region_ff;
   wire [7:0]  memWrites, memFaults;
   wire extCycle_ff, modeError_ff, internalSel_ff, low_byte_write_strobe_n, genericWriteStrobe_n;
   wire sharedPinOut, sharedPinOe, cpuClkEn_ff, perClkEn_ff, clock_output_pin;
   int err_count = 0, n_tests = 0, cCpu = 0, cPer = 0, cOut = 0;
   ebdws_row_t rows [13];
   logic [3:0] pm [3];
   ebdws_decode i_ebdws_decode (.clk, .rstn, .accValid, .accAddr, .accWrite, .accMode,
      .accLowByte, .accHighByte, .busWidth16, .internalMemEnable, .port5_pin_function_bit2,
      .write_strobe_select_bit, .port5Bit2Data, .fetchNext, .fetchAddr_ff, .region_ff,
      .extCycle_ff, .modeError_ff, .internalSel_ff, .low_byte_write_strobe_n,
      .genericWriteStrobe_n, .sharedPinOut, .sharedPinOe, .cpuClkEn_ff, .perClkEn_ff,
      .clock_output_pin);
   ebdws_ext_mem i_ebdws_ext_mem (.clk, .rstn, .low_byte_write_strobe_n, .extCycle_ff,
      .writeCount_ff(memWrites), .faultCount_ff(memFaults));
   initial forever #5 clk = ~clk;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      if (err_count == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One access pulse, outputs sampled once the answering edge has landed
   task automatic acc(input ebdws_row_t r);
      @(posedge clk);
      {accValid, accAddr, accWrite, accMode} <= {1'b1, r.a, r.w, r.m};
      {accLowByte, accHighByte, busWidth16, internalMemEnable} <= {r.lo, r.hi, r.b16, r.ie};
      @(posedge clk);
      accValid <= 1'b0;
      #1;
   endtask
   // Far more than the run needs, so only a hang trips it
   initial begin
      #20000;
      err_count++;
      complete_run();
   end
   initial begin
      rows = '{'{16'h0010,1,0,1,0,1,1,0,0,0,1,1}, '{16'h0100,0,1,0,0,1,1,1,0,0,1,1},
         '{16'h0200,0,0,0,0,1,1,0,0,1,1,1}, '{16'h0300,1,2,1,0,1,1,2,1,0,0,0},
         '{16'h1f00,0,1,0,0,1,1,3,0,0,1,1}, '{16'h1fe0,1,3,1,1,1,1,3,0,0,1,1},
         '{16'h2000,0,2,0,0,1,1,4,0,0,1,1}, '{16'h2080,1,2,1,1,1,1,5,0,0,1,1},
         '{16'h8000,1,3,0,1,1,1,2,1,0,1,0}, '{16'hffff,1,2,0,1,0,1,2,1,0,0,0},
         '{16'h8000,0,2,1,1,1,1,2,1,0,1,1}, '{16'h2080,0,3,0,0,1,0,5,1,0,1,1},
         '{16'h207f,0,0,0,0,1,1,0,0,1,1,1}};
      pm = '{4'b0111, 4'b1001, 4'b1110};
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      foreach (rows[i]) begin
         acc(rows[i]);
         if (!rows[i].er) chk(region_ff, rows[i].rg);
         chk(extCycle_ff, rows[i].ex);
         chk(modeError_ff, rows[i].er);
         chk(low_byte_write_strobe_n, rows[i].sl);
         chk(genericWriteStrobe_n, rows[i].sg);
      end
      // Port, low-byte and generic use of the shared pin on a high-lane write
      for (int k = 0; k < 3; k++) begin
         {port5_pin_function_bit2, write_strobe_select_bit, port5Bit2Data} <= pm[k][3:1];
         acc(rows[8]);
         chk(sharedPinOut, pm[k][0]);
      end
      chk(memWrites, 16'h0002);
      chk(memFaults, 16'h0000);
      repeat (16) begin
         @(posedge clk);
         #1;
         cCpu += cpuClkEn_ff;
         cPer += perClkEn_ff;
         cOut += clock_output_pin;
      end
      chk(cCpu, 16'h0008);
      chk(cPer, 16'h0004);
      chk(cOut, 16'h0008);
      @(posedge clk);
      fetchNext <= 1'b1;
      @(posedge clk);
      fetchNext <= 1'b0;
      #1;
      // Pointer must have moved, so the reset below has something to undo
      chk(fetchAddr_ff, 16'h2081);
      @(posedge clk);
      rstn <= 1'b0;
      @(posedge clk);
      rstn <= 1'b1;
      #1;
      chk(fetchAddr_ff, 16'h2080);
      chk(sharedPinOe, 16'h0001);
      complete_run();
   end
endmodule // ebdws_decode_bench

// file: dv/ebdws_decode_properties.sv
/* Port assertions for the decoder.
   Assumes one clock, async active-low reset. */
`timescale 1ns/1ps
module ebdws_decode_properties (
   input wire        clk, rstn, accValid, accWrite, accLowByte, busWidth16,
   input wire        port5_pin_function_bit2, write_strobe_select_bit, port5Bit2Data,
   input wire        extCycle_ff, modeError_ff, low_byte_write_strobe_n,
   input wire        genericWriteStrobe_n, sharedPinOut, cpuClkEn_ff,
   input wire [15:0] accAddr, fetchAddr_ff,
   input wire [1:0]  accMode,
   input wire [2:0]  region_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Off-chip windows, reached only through pointer modes
   wire extHit = accMode[1] && (accAddr[15] || (accAddr >= 16'h0300 && accAddr <= 16'h1eff));
   a_ext_route: assert property (accValid && extHit |=> extCycle_ff)
      else $error("external access gave no bus cycle");
   a_sfr_internal: assert property (accValid && accAddr[15:8] == 8'h1f |=> !extCycle_ff)
      else $error("SFR access went external");
   a_direct_refused: assert property (accValid && accMode == 2'h0 && accAddr > 16'h00ff
      |=> modeError_ff && !extCycle_ff) else $error("direct access not refused");
   a_lrf_region: assert property (accValid && accMode != 2'h1 && accAddr <= 16'h00ff
      |=> region_ff == 3'h0) else $error("lower file not decoded");
   a_pgm_region: assert property (accValid && accMode[1] && accAddr >= 16'h2080
      && !accAddr[15] |=> region_ff == 3'h5) else $error("program memory not decoded");
   a_generic_cause: assert property (!genericWriteStrobe_n
      |-> $past(accValid && accWrite) && extCycle_ff) else $error("stray generic strobe");
   a_low_strobe: assert property (accValid && accWrite && extHit
      && (accLowByte || !busWidth16) |=> !low_byte_write_strobe_n) else $error("no low strobe");
   a_pin_select: assert property (sharedPinOut == (!port5_pin_function_bit2 ?
      port5Bit2Data : write_strobe_select_bit ? genericWriteStrobe_n : low_byte_write_strobe_n))
      else $error("shared pin function wrong");
   a_reset_fetch: assert property (!$past(rstn) |-> fetchAddr_ff == 16'h2080)
      else $error("fetch not at start address");
   a_cpu_clock: assert property (cpuClkEn_ff |=> !cpuClkEn_ff ##1 cpuClkEn_ff)
      else $error("cpu enable period wrong");
endmodule // ebdws_decode_properties
bind ebdws_decode ebdws_decode_properties i_ebdws_decode_properties (.clk, .rstn, .accValid,
   .accWrite, .accLowByte, .busWidth16, .port5_pin_function_bit2, .write_strobe_select_bit,
   .port5Bit2Data, .extCycle_ff, .modeError_ff, .low_byte_write_strobe_n,
   .genericWriteStrobe_n, .sharedPinOut, .cpuClkEn_ff, .accAddr, .fetchAddr_ff, .accMode,
   .region_ff);

// file: dv/ebdws_ext_mem.sv
/* External memory seen through the low-byte write strobe.
   Assumes strobes are registered on clk beside the external cycle flag. */
`timescale 1ns/1ps
module ebdws_ext_mem (
   input wire       clk,
   input wire       rstn,
   input wire       low_byte_write_strobe_n,
   input wire       extCycle_ff,
   output reg [7:0] writeCount_ff,
   output reg [7:0] faultCount_ff
);
   // A strobe outside an external cycle is a fault, not a write
   // No contents kept for the reserved low window
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         writeCount_ff <= 8'h00;
         faultCount_ff <= 8'h00;
      end else if (!low_byte_write_strobe_n) begin
         if (extCycle_ff) writeCount_ff <= writeCount_ff + 8'h01;
         else faultCount_ff <= faultCount_ff + 8'h01;
      end
   end
endmodule // ebdws_ext_mem

// file: pkg/ebdws_map.vh
/*
 Constants for the external bus address decoder and write-strobe selector:
 region bounds, reset fetch address, clock divider counts, decode codes.
 Assumes inclusion by bare name from the design file.
*/
`ifndef EBDWS_MAP_VH
`define EBDWS_MAP_VH

// Region bounds, inclusive
`define EBDWS_LRF_LO        16'h0000
`define EBDWS_LRF_HI        16'h00ff
`define EBDWS_URF_LO        16'h0100
`define EBDWS_URF_HI        16'h02ff
`define EBDWS_EXTLO_LO      16'h0300
`define EBDWS_EXTLO_HI      16'h1eff
`define EBDWS_SFR_LO        16'h1f00
`define EBDWS_SFR_HI        16'h1fff
`define EBDWS_SPM_LO        16'h2000
`define EBDWS_SPM_HI        16'h207f
`define EBDWS_PGM_LO        16'h2080
`define EBDWS_PGM_HI        16'h7fff
`define EBDWS_EXTHI_LO      16'h8000
`define EBDWS_EXTHI_HI      16'hffff

// First instruction fetch after any reset
`define EBDWS_RESET_FETCH   16'h2080

// Region codes
`define EBDWS_RGN_LRF       3'h0
`define EBDWS_RGN_URF       3'h1
`define EBDWS_RGN_EXT       3'h2
`define EBDWS_RGN_SFR       3'h3
`define EBDWS_RGN_SPM       3'h4
`define EBDWS_RGN_PGM       3'h5

// Addressing modes
`define EBDWS_AM_DIRECT     2'h0
`define EBDWS_AM_WINDOW     2'h1
`define EBDWS_AM_INDIRECT   2'h2
`define EBDWS_AM_INDEXED    2'h3

// Clock generator: halves per output toggle
`define EBDWS_CPU_DIV_HALF  4'h1
`define EBDWS_PER_DIV_HALF  4'h2
`define EBDWS_OUT_DIV_HALF  4'h4
`define EBDWS_DIV_ONE       4'h1
`define EBDWS_DIV_ZERO      4'h0

`endif

// file: rtl/ebdws_decode.v
/*
 External bus address decoder and write-strobe selector.
 Decodes each CPU access into a region, raises an external bus cycle where
 the region lives off chip, and drives the shared strobe pin as low-byte or
 generic write strobe or as a plain port pin. Also derives the enable pulses
 for the CPU and peripheral clocks and the clock output pin.
 Assumes all inputs synchronous to clk, one access request per valid pulse,
 and that fetchable program memory is the only region reached by fetches.
*/
`timescale 1ns/1ps
`include "ebdws_map.vh"

// Operation
// - On a 16-bit bus the low-byte strobe is driven low for low-byte writes and word writes.
// - On an 8-bit bus the low-byte strobe is driven low for every external write.
// - The shared pin carries a strobe only when the port 5 pin-function bit 2 is set.
// - With the pin in strobe use, the select bit picks the generic strobe at 1 and low-byte at 0.
// - After any reset instruction fetching starts at address 2080h.
// - Ranges 8000h-FFFFh and 0300h-1EFFh go to the external bus by indirect or indexed access.
// - Range 2080h-7FFFh decodes to program memory, internal or external.
// - Range 2000h-207Fh decodes to special-purpose memory, indirect or indexed only.
// - Range 0100h-02FFh is upper register RAM, by indirect, indexed or windowed direct.
// - Range 0000h-00FFh is the lower register file with RAM, stack pointer and CPU SFRs.
// - Only the lower register file accepts plain direct addressing.
// - The clock generators derive CPU, peripheral and clock output from the input clock.
// - The generic strobe is driven low only during external write cycles.
module ebdws_decode (
   input  wire        clk,
   input  wire        rstn,
   input  wire        accValid,
   input  wire [15:0] accAddr,
   input  wire        accWrite,
   input  wire [1:0]  accMode,
   input  wire        accLowByte,
   input  wire        accHighByte,
   input  wire        busWidth16,
   input  wire        internalMemEnable,
   input  wire        port5_pin_function_bit2,
   input  wire        write_strobe_select_bit,
   input  wire        port5Bit2Data,
   input  wire        fetchNext,
   output reg  [15:0] fetchAddr_ff,
   output reg  [2:0]  region_ff,
   output reg         extCycle_ff,
   output reg         modeError_ff,
   output reg         internalSel_ff,
   output reg         low_byte_write_strobe_n,
   output reg         genericWriteStrobe_n,
   output wire        sharedPinOut,
   output wire        sharedPinOe,
   output reg         cpuClkEn_ff,
   output reg         perClkEn_ff,
   output reg         clock_output_pin
);

   reg  [2:0]  nxtRegion;
   reg         nxtModeOk;
   reg         nxtExt;
   reg  [3:0]  cpuCnt_ff;
   reg  [3:0]  perCnt_ff;
   reg  [3:0]  outCnt_ff;
   wire        inLrf;
   wire        inUrf;
   wire        inExtLo;
   wire        inSfr;
   wire        inSpm;
   wire        inPgm;
   wire        inExtHi;
   wire        modeIndir;
   wire        extWrite;
   wire        nxt_lowStrobe;

   // Enable pulses repeat once per full divided period, which is two halves long;
   // comparing against the half count alone would fire twice as often
   localparam [3:0] CPU_LAST = (`EBDWS_CPU_DIV_HALF << `EBDWS_DIV_ONE) - `EBDWS_DIV_ONE;
   localparam [3:0] PER_LAST = (`EBDWS_PER_DIV_HALF << `EBDWS_DIV_ONE) - `EBDWS_DIV_ONE;

   // Region compare, each bound inclusive
   assign inLrf   = accAddr <= `EBDWS_LRF_HI;
   assign inUrf   = accAddr >= `EBDWS_URF_LO && accAddr <= `EBDWS_URF_HI;
   assign inExtLo = accAddr >= `EBDWS_EXTLO_LO && accAddr <= `EBDWS_EXTLO_HI;
   assign inSfr   = accAddr >= `EBDWS_SFR_LO && accAddr <= `EBDWS_SFR_HI;
   assign inSpm   = accAddr >= `EBDWS_SPM_LO && accAddr <= `EBDWS_SPM_HI;
   assign inPgm   = accAddr >= `EBDWS_PGM_LO && accAddr <= `EBDWS_PGM_HI;
   assign inExtHi = accAddr >= `EBDWS_EXTHI_LO;
   assign modeIndir = accMode == `EBDWS_AM_INDIRECT || accMode == `EBDWS_AM_INDEXED;

   // Region, legal mode and external cycle; the reserved low external range is
   // decoded like any external range so later SFRs there need no decoder change
   always @* begin
      nxtRegion = `EBDWS_RGN_EXT;
      nxtModeOk = modeIndir;
      nxtExt    = 1'b0;
      if (inLrf) begin
         nxtRegion = `EBDWS_RGN_LRF;
         nxtModeOk = accMode != `EBDWS_AM_WINDOW;
      end else if (inUrf) begin
         nxtRegion = `EBDWS_RGN_URF;
         nxtModeOk = accMode != `EBDWS_AM_DIRECT;
      end else if (inSfr) begin
         nxtRegion = `EBDWS_RGN_SFR;
         // Only the peripheral part accepts windowed direct; kept simple here
         nxtModeOk = accMode != `EBDWS_AM_DIRECT;
      end else if (inSpm) begin
         nxtRegion = `EBDWS_RGN_SPM;
         nxtExt    = ~internalMemEnable;
      end else if (inPgm) begin
         nxtRegion = `EBDWS_RGN_PGM;
         nxtExt    = ~internalMemEnable;
      end else if (inExtLo || inExtHi) begin
         nxtRegion = `EBDWS_RGN_EXT;
         nxtExt    = 1'b1;
      end
      // An access in an illegal mode is refused and starts no bus cycle
      if (!nxtModeOk) begin
         nxtExt = 1'b0;
      end
   end

   assign extWrite      = accValid & accWrite & nxtExt;
   assign nxt_lowStrobe = busWidth16 ? (extWrite & accLowByte)
                                     : extWrite;

   // Decode outputs and strobes, registered so the pin never glitches
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         region_ff               <= `EBDWS_RGN_LRF;
         extCycle_ff             <= 1'b0;
         modeError_ff            <= 1'b0;
         internalSel_ff          <= 1'b0;
         low_byte_write_strobe_n <= 1'b1;
         genericWriteStrobe_n    <= 1'b1;
      end else begin
         region_ff               <= accValid ? nxtRegion : region_ff;
         extCycle_ff             <= accValid & nxtExt;
         modeError_ff            <= accValid & ~nxtModeOk;
         internalSel_ff          <= accValid & nxtModeOk & ~nxtExt;
         low_byte_write_strobe_n <= ~nxt_lowStrobe;
         genericWriteStrobe_n    <= ~extWrite;
      end
   end

   // Shared pin: strobe function or plain port, strobe kind by select bit
   assign sharedPinOut = port5_pin_function_bit2 ?
                         (write_strobe_select_bit ? genericWriteStrobe_n
                                                  : low_byte_write_strobe_n)
                         : port5Bit2Data;
   assign sharedPinOe  = 1'b1;

   // Fetch pointer restarts at the reset vector on every reset
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fetchAddr_ff <= `EBDWS_RESET_FETCH;
      end else if (fetchNext) begin
         fetchAddr_ff <= fetchAddr_ff + 16'h0001;
      end
   end

   // Clock generators: enables instead of gated clocks keep one clock tree
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cpuCnt_ff        <= `EBDWS_DIV_ZERO;
         perCnt_ff        <= `EBDWS_DIV_ZERO;
         outCnt_ff        <= `EBDWS_DIV_ZERO;
         cpuClkEn_ff      <= 1'b0;
         perClkEn_ff      <= 1'b0;
         clock_output_pin <= 1'b0;
      end else begin
         cpuClkEn_ff <= cpuCnt_ff == CPU_LAST;
         perClkEn_ff <= perCnt_ff == PER_LAST;
         cpuCnt_ff   <= (cpuCnt_ff == CPU_LAST) ?
                        `EBDWS_DIV_ZERO : cpuCnt_ff + `EBDWS_DIV_ONE;
         perCnt_ff   <= (perCnt_ff == PER_LAST) ?
                        `EBDWS_DIV_ZERO : perCnt_ff + `EBDWS_DIV_ONE;
         if (outCnt_ff == `EBDWS_OUT_DIV_HALF - `EBDWS_DIV_ONE) begin
            outCnt_ff        <= `EBDWS_DIV_ZERO;
            clock_output_pin <= ~clock_output_pin;
         end else begin
            outCnt_ff <= outCnt_ff + `EBDWS_DIV_ONE;
         end
      end
   end

endmodule // ebdws_decode
